//--- srap_pkg.sv
// package for the serial register access port
package srap_pkg;
  localparam int FRAME_BITS = 40;
  localparam int DATA_BITS = 32;
  localparam int ADDR_BITS = 7;
  localparam int DIR_BIT_POS = 39;
  localparam int STATUS_LSB = 32;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [39:0] SHIFT_RESET = 40'h0000000000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [5:0] BITCNT_RESET = 6'h00;
  localparam logic [5:0] BITCNT_FULL = 6'h28;
  // status byte field positions
  localparam int ST_RESET_POS = 0;
  localparam int ST_DRV_ERR1_POS = 1;
  localparam int ST_DRV_ERR2_POS = 2;
  localparam int ST_VREACH1_POS = 3;
  localparam int ST_VREACH2_POS = 4;
  localparam int ST_STOPL1_POS = 5;
  localparam int ST_STOPL2_POS = 6;
  localparam int ST_RSVD_POS = 7;
  // global status register address (reading it clears its flags)
  localparam logic [6:0] GLOBAL_STATUS_ADDR = 7'h01;

  typedef struct packed {
    logic direction_select_bit;
    logic [6:0] addr;
    logic [31:0] data;
  } srap_frame_t;

  typedef struct packed {
    logic stop_left2;
    logic stop_left1;
    logic vel_reached2;
    logic vel_reached1;
  } srap_ramp_t;

  typedef struct packed {
    logic drv_err2;
    logic drv_err1;
    logic reset_flag;
  } srap_gflags_t;

  typedef enum logic [1:0] {
    SRAP_IDLE,
    SRAP_SHIFT,
    SRAP_EXEC
  } srap_state_t;
endpackage

//--- srap_port.sv
// serial register access port: slave side of the 40-bit register datagram link
`timescale 1ns/1ns
module srap_port
  import srap_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic reset_n,
  // serial link pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic cs_n,
  output logic sdo,
  output logic sdo_oe,
  // register file side
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // status sources
  input wire srap_ramp_t ramp_status,
  input wire srap_gflags_t global_status_register,
  // global status flags cleared by a read of that register
  output logic global_status_clear
);

  // edge of a synchronised level against its copy one clock older
  function automatic logic rise_of(input logic now_level, input logic old_level);
    return now_level && !old_level;
  endfunction

  function automatic logic fall_of(input logic now_level, input logic old_level);
    return !now_level && old_level;
  endfunction

  // status byte from live flags; the reserved bit always reads zero
  function automatic logic [7:0] pack_status(input srap_ramp_t rp, input srap_gflags_t gs);
    logic [7:0] byte_v;
    byte_v = STATUS_RESET;
    byte_v[ST_RESET_POS] = gs.reset_flag;
    byte_v[ST_DRV_ERR1_POS] = gs.drv_err1;
    byte_v[ST_DRV_ERR2_POS] = gs.drv_err2;
    byte_v[ST_VREACH1_POS] = rp.vel_reached1;
    byte_v[ST_VREACH2_POS] = rp.vel_reached2;
    byte_v[ST_STOPL1_POS] = rp.stop_left1;
    byte_v[ST_STOPL2_POS] = rp.stop_left2;
    byte_v[ST_RSVD_POS] = 1'b0;
    return byte_v;
  endfunction

  // synchroniser stages, plus one older copy of sck and cs for edges
  logic sck_s1;
  logic sck_s2;
  logic sck_d;
  logic sdi_s1;
  logic sdi_s2;
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  // frame controller
  srap_state_t state;
  srap_state_t next_state;
  logic [39:0] shift;
  logic [5:0] bitcnt;
  srap_frame_t cmd;
  // reply pipeline
  logic [7:0] status;
  logic [31:0] reply_data;
  // next values of the registers
  logic [39:0] next_shift;
  logic [5:0] next_bitcnt;
  logic [39:0] next_cmd;
  logic next_reg_wr;
  logic next_reg_rd;
  logic next_global_status_clear;
  logic [6:0] next_reg_addr;
  logic [31:0] next_reg_wdata;
  logic [7:0] next_status_byte;
  logic [31:0] next_reply_data;
  logic next_sdo_oe;
  logic next_sdo;

  // sck: two flops against metastability, a third for the edge
  // reset values match the idle pins, so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
    end
  end

  // sdi: same delay as sck, so each bit meets its own edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  // cs_n: two flops against metastability, a third for the edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
    end
  end

  // edges on synchronised levels; sck counts only while selected
  wire selected = !cs_s2 && !cs_d;
  wire sck_rise = selected && rise_of(sck_s2, sck_d);
  wire sck_fall = selected && fall_of(sck_s2, sck_d);
  wire cs_fall = fall_of(cs_s2, cs_d);
  wire cs_rise = rise_of(cs_s2, cs_d);

  // qualified events of the frame controller
  wire load_reply = (state == SRAP_IDLE) && cs_fall;
  wire take_cmd = (state == SRAP_SHIFT) && cs_rise;
  // a late sck edge in the clock that cs rises is not shifted in
  wire take_bit = (state == SRAP_SHIFT) && !cs_rise && sck_rise;
  wire drive_bit = (state == SRAP_SHIFT) && sck_fall;
  wire in_exec = (state == SRAP_EXEC);
  wire frame_ok = (bitcnt == BITCNT_FULL);
  wire is_write = cmd.direction_select_bit;

  // data paths
  wire [39:0] shift_in = {shift[38:0], sdi_s2};
  wire [39:0] reply_word = {status, reply_data};
  wire [7:0] next_status = pack_status(ramp_status, global_status_register);
  // the count saturates, so longer frames keep only the last 40 bits
  wire [5:0] bitcnt_step = frame_ok ? bitcnt : bitcnt + 6'h01;

  // shifter: loaded with the reply as cs falls, then one bit per sck rise
  assign next_shift = load_reply ? reply_word :
    take_bit ? shift_in :
    shift;
  assign next_bitcnt = load_reply ? BITCNT_RESET :
    take_bit ? bitcnt_step :
    bitcnt;
  assign next_cmd = take_cmd ? shift :
    cmd;
  // strobes last one clock; the register file acts on them
  assign next_reg_wr = in_exec && is_write;
  assign next_reg_rd = in_exec && !is_write;
  assign next_global_status_clear = next_reg_rd && (cmd.addr == GLOBAL_STATUS_ADDR);
  // address and write data hold until the next command
  assign next_reg_addr = in_exec ? cmd.addr :
    reg_addr;
  assign next_reg_wdata = next_reg_wr ? cmd.data :
    reg_wdata;
  assign next_status_byte = in_exec ? next_status :
    status;
  // read data arrives one clock after its strobe
  assign next_reply_data = next_reg_wr ? cmd.data :
    reg_rd ? reg_rdata :
    reply_data;
  // the pin is released as soon as the synchronised cs goes high
  assign next_sdo_oe = (state == SRAP_SHIFT) && !cs_s2;
  assign next_sdo = load_reply ? reply_word[39] :
    drive_bit ? shift[39] :
    sdo;

  // frame controller: idle, shifting, one clock of execution
  always_comb begin
    next_state = state;
    case (state)
      SRAP_IDLE: begin
        if (cs_fall) begin
          next_state = SRAP_SHIFT;
        end
      end
      SRAP_SHIFT: begin
        // a frame shorter than 40 bits is dropped with no access
        if (cs_rise) begin
          next_state = frame_ok ? SRAP_EXEC : SRAP_IDLE;
        end
      end
      SRAP_EXEC: begin
        next_state = SRAP_IDLE;
      end
      default: begin
        next_state = SRAP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SRAP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // shift register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift <= SHIFT_RESET;
    end else begin
      shift <= next_shift;
    end
  end

  // received bit count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitcnt <= BITCNT_RESET;
    end else begin
      bitcnt <= next_bitcnt;
    end
  end

  // command taken as cs rises
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= SHIFT_RESET;
    end else begin
      cmd <= next_cmd;
    end
  end

  // write strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_wr <= 1'b0;
    end else begin
      reg_wr <= next_reg_wr;
    end
  end

  // read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd <= 1'b0;
    end else begin
      reg_rd <= next_reg_rd;
    end
  end

  // clear request for the global status flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      global_status_clear <= 1'b0;
    end else begin
      global_status_clear <= next_global_status_clear;
    end
  end

  // register address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_addr <= 7'h00;
    end else begin
      reg_addr <= next_reg_addr;
    end
  end

  // write data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_wdata <= DATA_RESET;
    end else begin
      reg_wdata <= next_reg_wdata;
    end
  end

  // status byte latched at the end of each executed access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status_byte;
    end
  end

  // reply data: read data of the previous read, or echo of the previous write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reply_data <= DATA_RESET;
    end else begin
      reply_data <= next_reply_data;
    end
  end

  // output enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= next_sdo_oe;
    end
  end

  // serial output, loaded with the reply msb as cs falls, then moved only after a falling sck
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo <= 1'b0;
    end else begin
      sdo <= next_sdo;
    end
  end
endmodule

//--- srap_port_checker.sv
// assertions on the pins of the serial register access port
`timescale 1ns/1ns
module srap_port_checker
  import srap_pkg::*;
(
  // watched pins
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic global_status_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  one_strobe_a: assert property (!(reg_wr && reg_rd))
    else $error("write and read strobes together");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  rd_pulse_a: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe too long");
  clear_on_rd_a: assert property (global_status_clear |-> reg_rd && reg_addr == GLOBAL_STATUS_ADDR)
    else $error("status clear without its read");
  idle_release_a: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("output driven while deselected");
  exec_after_cs_a: assert property ((reg_wr || reg_rd) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("command run before chip select rose");
  sdo_hold_a: assert property (sck [*4] ##0 sdo_oe && $past(sdo_oe) |-> $stable(sdo))
    else $error("output moved without a falling clock");
  wr_hold_a: assert property (reg_wr |=> $stable(reg_addr) && $stable(reg_wdata))
    else $error("write address or data did not hold");
  cover property (reg_wr);
  cover property (reg_rd ##1 !reg_rd);
  cover property (global_status_clear);
endmodule

//--- srap_master.sv
// bus master model that clocks frames through the port
`timescale 1ns/1ns
module srap_master (
  // system
  input wire logic clk,
  // link pins
  output logic sck,
  output logic sdi,
  output logic cs_n,
  input wire logic sdo
);
  initial begin
    sck = 1'b1;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  // n bits of tx msb first, 160 ns per half period
  task automatic xfer(input logic [79:0] tx, input int n, output logic [79:0] rx);
    rx = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      rx = {rx[78:0], sdo};
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule

//--- test_spi_register_access_port.sv
// testbench for the serial register access port
`timescale 1ns/1ns
module test_spi_register_access_port
  import srap_pkg::*;
;
  typedef struct packed {
    logic [39:0] tx;
    srap_ramp_t rp;
    srap_gflags_t gs;
    logic [39:0] ex;
  } srap_row_t;
  localparam srap_row_t ROWS [5] = '{
    '{40'ha200abcdef, 4'h5, 3'h0, 40'h0000000000},
    '{40'ha700123456, 4'ha, 3'h7, 40'h2800abcdef},
    '{40'h22ffffffff, 4'h0, 3'h5, 40'h5700123456},
    '{40'h2700000000, 4'hf, 3'h2, 40'h0500abcdef},
    '{40'h0100000000, 4'h0, 3'h0, 40'h7a00123456}};
  logic clk, reset_n, sck, sdi, cs_n, sdo, sdo_oe, reg_wr, reg_rd, global_status_clear;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] regs [128];
  srap_ramp_t ramp_status;
  srap_gflags_t global_status_register;
  logic [79:0] rx;
  logic [7:0] clear_count;
  int fail_count, comparisons;
  srap_port u_dut (.clk, .reset_n, .sck, .sdi, .cs_n, .sdo, .sdo_oe, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .ramp_status, .global_status_register,
    .global_status_clear);
  srap_master u_master (.clk, .sck, .sdi, .cs_n, .sdo);
  always #20 clk = ~clk;
  always @(posedge clk) if (reg_wr === 1'b1) regs[reg_addr] <= reg_wdata;
  always @(posedge clk) if (global_status_clear === 1'b1) clear_count <= clear_count + 8'h01;
  assign reg_rdata = regs[reg_addr];
  task check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    fail_count = 0;
    comparisons = 0;
    clear_count = 8'h00;
    regs[1] = 32'h00000003;
    clk = 1'b0;
    reset_n = 1'b0;
    ramp_status = '0;
    global_status_register = '0;
    repeat (2) @(posedge clk);
    check({78'h0, sdo_oe, reg_wr}, 80'h0);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      ramp_status <= ROWS[k].rp;
      global_status_register <= ROWS[k].gs;
      u_master.xfer({40'h0, ROWS[k].tx}, 40, rx);
      check(rx, {40'h0, ROWS[k].ex});
      $display("row %0d done", k);
    end
    u_master.xfer(80'ha2ffff, 24, rx);
    u_master.xfer({32'h0, 8'h5a, 40'ha200000011}, 48, rx);
    check(rx, {32'h0, 40'h0000000003, 8'h5a});
    check({48'h0, reg_wdata}, {48'h0, 32'h00000011});
    u_master.xfer({40'h0, 40'h2200000000}, 40, rx);
    check(rx, {40'h0, 40'h0000000011});
    check({72'h0, clear_count}, 80'h1);
    $display("hand tests done");
    results();
  end
endmodule
bind srap_port srap_port_checker u_chk (.clk, .reset_n, .sck, .cs_n, .sdo, .sdo_oe,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .global_status_clear);
